// ==== design/msr_pkg.sv ====
// Constants shared by the Modbus status and exception responder
package msr_pkg;

  // ----------------------------------------------------------------
  // Function codes and exception coding
  // ----------------------------------------------------------------
  localparam logic [7:0] MSR_FC_READ = 8'h03;
  localparam logic [7:0] MSR_FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] MSR_FC_WRITE_MANY = 8'h10;
  localparam logic [7:0] MSR_EXC_FLAG = 8'h80;
  localparam logic [7:0] MSR_EXC_NONE = 8'h00;
  localparam logic [7:0] MSR_EXC_FUNC = 8'h01;
  localparam logic [7:0] MSR_EXC_ADDR = 8'h02;
  localparam logic [7:0] MSR_EXC_DATA = 8'h03;
  localparam logic [7:0] MSR_EXC_EXEC = 8'h04;

  // ----------------------------------------------------------------
  // Monitor word addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] MSR_A_DOUT_STATE = 16'h2211;
  localparam logic [15:0] MSR_A_MULTISTEP = 16'h2212;
  localparam logic [15:0] MSR_A_IN_PINS = 16'h2213;
  localparam logic [15:0] MSR_A_OUT_PINS = 16'h2214;
  localparam logic [15:0] MSR_A_ENC_REVS = 16'h2215;
  localparam logic [15:0] MSR_A_PULSE_FREQ = 16'h2216;
  localparam logic [15:0] MSR_A_PULSE_POS = 16'h2217;
  localparam logic [15:0] MSR_A_TRACK_ERR = 16'h2218;
  localparam logic [15:0] MSR_A_OVERLOAD = 16'h2219;
  localparam logic [15:0] MSR_A_POLES = 16'h221D;
  localparam logic [15:0] MSR_A_USER_PAGE = 16'h221E;
  localparam logic [15:0] MSR_A_SEL_DISPLAY = 16'h221F;
  localparam logic [15:0] MSR_A_TURNS = 16'h2220;
  localparam logic [15:0] MSR_A_OP_POS = 16'h2221;
  localparam logic [15:0] MSR_A_FAN = 16'h2222;
  localparam logic [15:0] MSR_A_CTRL_MODE = 16'h2223;
  localparam logic [15:0] MSR_A_CARRIER = 16'h2224;
  localparam logic [15:0] MSR_A_RESERVED = 16'h2225;
  localparam logic [15:0] MSR_A_STATE_FLAGS = 16'h2226;
  localparam logic [15:0] MSR_A_TORQUE_EST = 16'h2227;
  localparam logic [15:0] MSR_A_TORQUE_CMD = 16'h2228;
  localparam logic [15:0] MSR_A_ENERGY = 16'h2229;
  localparam logic [15:0] MSR_A_TERM_LOW = 16'h222A;
  localparam logic [15:0] MSR_A_TERM_HIGH = 16'h222B;
  localparam logic [15:0] MSR_A_MPOS_LOW = 16'h222C;
  localparam logic [15:0] MSR_A_MPOS_HIGH = 16'h222D;
  localparam logic [15:0] MSR_A_HW_ID = 16'h2231;
  localparam logic [15:0] MSR_A_MASTER_FREQ = 16'h2233;
  localparam logic [15:0] MSR_A_COMBINED_FREQ = 16'h2234;

  // ----------------------------------------------------------------
  // Field layout of the drive state word
  // ----------------------------------------------------------------
  localparam int MSR_B_DIR_LO = 0;
  localparam int MSR_B_DIR_HI = 1;
  localparam int MSR_B_RDY_LO = 2;
  localparam int MSR_B_RDY_HI = 3;
  localparam int MSR_B_OUTPUT = 4;
  localparam int MSR_B_ALARM = 5;
  localparam logic [1:0] MSR_DIR_NONE = 2'h0;
  localparam logic [1:0] MSR_DIR_FWD = 2'h1;
  localparam logic [1:0] MSR_DIR_REV = 2'h2;
  localparam logic [1:0] MSR_RDY_OK = 2'h1;
  localparam logic [1:0] MSR_RDY_ERR = 2'h2;
  localparam logic [15:0] MSR_MODE_SPEED = 16'h0000;
  localparam logic [15:0] MSR_MODE_TORQUE = 16'h0001;

  // ----------------------------------------------------------------
  // Limits and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] MSR_WORD_MAX = 16'hFFFF;
  localparam logic [15:0] MSR_MAX_READ_WORDS = 16'h0008;
  localparam int MSR_MAX_READ = 8;
  // Delay setting is held in tenths of a millisecond
  localparam logic [15:0] MSR_DELAY_MAX_TENTHS = 16'h07D0;
  localparam logic [15:0] MSR_DELAY_DEF_TENTHS = 16'h0014;
  localparam int MSR_CLK_PERIOD_NS = 10;
  localparam int MSR_DELAY_STEP_NS = 100000;
  localparam int MSR_DELAY_STEP_CYCLES = MSR_DELAY_STEP_NS / MSR_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MSR_IDLE = 2'b00,
    MSR_CHECK = 2'b01,
    MSR_WAIT = 2'b10,
    MSR_SEND = 2'b11
  } msr_state_t;

endpackage : msr_pkg

// ==== design/msr_responder.sv ====
// Modbus status word responder with exception replies and reply delay

// Overview of operation
// - A request that cannot be served is answered with its function code with bit 7 set, followed by an exception code.
// - The exception code is 1 for a bad function, 2 for a bad address, 3 for bad data and 4 when the function cannot be executed.
// - Every reply waits a programmable delay of 0.0 to 200.0 ms, 2.0 ms by default, after the request is taken.
// - Bits 1 to 0 of the drive state word read 00 with no direction, 01 forward and 10 reverse.
// - Bits 3 to 2 of the drive state word read 01 when ready and 10 on error.
// - Bit 4 of the drive state word shows output active and bit 5 shows an alarm present.
// - The control mode word reads 0 in speed mode and 1 in torque mode.
// - The first encoder revolution count restarts on a direction change or a zero stop display and saturates at 65535.
// - The motor turns count holds while stopped and clears when operation starts.
// - The motor operation position holds while stopped and clears when operation starts.
// - The second encoder pulse position is one word that saturates at 65535.
// - The pulse input terminal count is 32 bits, low word then high word at consecutive addresses.
// - The motor actual position is 32 bits read as a low word and a high word.
module msr_responder import msr_pkg::*; #(
  parameter int DELAY_STEP_CYCLES = MSR_DELAY_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_count,
  input wire logic delay_load,
  input wire logic [15:0] delay_tenths,
  input wire logic run_forward,
  input wire logic run_reverse,
  input wire logic drive_fault,
  input wire logic drive_output,
  input wire logic drive_alarm,
  input wire logic torque_mode,
  input wire logic drive_running,
  input wire logic stop_display_zero,
  input wire logic first_encoder_input,
  input wire logic second_encoder_input,
  input wire logic pulse_input_terminal,
  input wire logic motor_turn_tick,
  input wire logic motor_position_tick,
  input wire logic [31:0] motor_actual_position,
  input wire logic [15:0] digital_output_state,
  input wire logic [15:0] active_multistep_speed,
  input wire logic [15:0] input_pin_state,
  input wire logic [15:0] output_pin_state,
  input wire logic [15:0] pulse_input_frequency,
  input wire logic [15:0] position_tracking_error,
  input wire logic [15:0] overload_counter_percent,
  input wire logic [15:0] magnet_motor_poles,
  input wire logic [15:0] user_page_value,
  input wire logic [15:0] selected_display_output,
  input wire logic [15:0] fan_speed_percent,
  input wire logic [15:0] carrier_frequency,
  input wire logic [15:0] estimated_output_torque,
  input wire logic [15:0] torque_command_percent,
  input wire logic [15:0] energy_kwh,
  input wire logic [15:0] hardware_identity,
  input wire logic [15:0] master_frequency_display,
  input wire logic [15:0] combined_frequency_display,
  output logic busy,
  output logic resp_valid,
  output logic resp_exception,
  output logic resp_last,
  output logic [7:0] resp_func,
  output logic [7:0] resp_code,
  output logic [15:0] resp_word
);

  typedef struct packed {
    msr_state_t state;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] count;
    logic [15:0] idx;
    logic [7:0] exc;
    logic [15:0] delay_tenths;
    logic [15:0] tenth_cnt;
    logic [15:0] step_cnt;
    logic [1:0] prev_dir;
    logic prev_run;
    logic [15:0] enc_revs;
    logic [15:0] turns;
    logic [15:0] op_pos;
    logic [15:0] pg2_pos;
    logic [31:0] term_cnt;
    logic [15:0] state_flags;
    logic [15:0] ctrl_mode;
    logic busy;
    logic resp_valid;
    logic resp_exception;
    logic resp_last;
    logic [7:0] resp_func;
    logic [7:0] resp_code;
    logic [15:0] resp_word;
    logic [15:0] beat_addr;
  } msr_regs_t;

  localparam logic [15:0] STEP_LAST = 16'(DELAY_STEP_CYCLES - 1);

  msr_regs_t s;
  msr_regs_t next_s;
  logic [15:0] rd_addr;
  logic [15:0] rd_word;
  logic [1:0] dir_code;
  logic [7:0] check_code;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  function automatic logic msr_mapped(input logic [15:0] a);
    unique case (a)
      MSR_A_DOUT_STATE, MSR_A_MULTISTEP, MSR_A_IN_PINS, MSR_A_OUT_PINS,
      MSR_A_ENC_REVS, MSR_A_PULSE_FREQ, MSR_A_PULSE_POS, MSR_A_TRACK_ERR,
      MSR_A_OVERLOAD, MSR_A_POLES, MSR_A_USER_PAGE, MSR_A_SEL_DISPLAY,
      MSR_A_TURNS, MSR_A_OP_POS, MSR_A_FAN, MSR_A_CTRL_MODE, MSR_A_CARRIER,
      MSR_A_RESERVED, MSR_A_STATE_FLAGS, MSR_A_TORQUE_EST, MSR_A_TORQUE_CMD,
      MSR_A_ENERGY, MSR_A_TERM_LOW, MSR_A_TERM_HIGH, MSR_A_MPOS_LOW,
      MSR_A_MPOS_HIGH, MSR_A_HW_ID, MSR_A_MASTER_FREQ,
      MSR_A_COMBINED_FREQ: msr_mapped = 1'b1;
      default: msr_mapped = 1'b0;
    endcase
  endfunction : msr_mapped

  assign rd_addr = s.addr + s.idx;
  assign dir_code = run_reverse ? MSR_DIR_REV :
                    (run_forward ? MSR_DIR_FWD : MSR_DIR_NONE);

  always_comb begin
    unique case (rd_addr)
      MSR_A_DOUT_STATE: rd_word = digital_output_state;
      MSR_A_MULTISTEP: rd_word = active_multistep_speed;
      MSR_A_IN_PINS: rd_word = input_pin_state;
      MSR_A_OUT_PINS: rd_word = output_pin_state;
      MSR_A_ENC_REVS: rd_word = s.enc_revs;
      MSR_A_PULSE_FREQ: rd_word = pulse_input_frequency;
      MSR_A_PULSE_POS: rd_word = s.pg2_pos;
      MSR_A_TRACK_ERR: rd_word = position_tracking_error;
      MSR_A_OVERLOAD: rd_word = overload_counter_percent;
      MSR_A_POLES: rd_word = magnet_motor_poles;
      MSR_A_USER_PAGE: rd_word = user_page_value;
      MSR_A_SEL_DISPLAY: rd_word = selected_display_output;
      MSR_A_TURNS: rd_word = s.turns;
      MSR_A_OP_POS: rd_word = s.op_pos;
      MSR_A_FAN: rd_word = fan_speed_percent;
      MSR_A_CTRL_MODE: rd_word = s.ctrl_mode;
      MSR_A_CARRIER: rd_word = carrier_frequency;
      MSR_A_STATE_FLAGS: rd_word = s.state_flags;
      MSR_A_TORQUE_EST: rd_word = estimated_output_torque;
      MSR_A_TORQUE_CMD: rd_word = torque_command_percent;
      MSR_A_ENERGY: rd_word = energy_kwh;
      MSR_A_TERM_LOW: rd_word = s.term_cnt[15:0];
      MSR_A_TERM_HIGH: rd_word = s.term_cnt[31:16];
      MSR_A_MPOS_LOW: rd_word = motor_actual_position[15:0];
      MSR_A_MPOS_HIGH: rd_word = motor_actual_position[31:16];
      MSR_A_HW_ID: rd_word = hardware_identity;
      MSR_A_MASTER_FREQ: rd_word = master_frequency_display;
      MSR_A_COMBINED_FREQ: rd_word = combined_frequency_display;
      default: rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Request check
  // ----------------------------------------------------------------
  // Scans the whole span so that no word of a reply is ever unmapped
  always_comb begin
    logic span_bad;
    logic span_long;
    span_bad = 1'b0;
    span_long = (s.count == 16'h0000) || (s.count > MSR_MAX_READ_WORDS);
    for (int i = 0; i < MSR_MAX_READ; i++) begin
      if (16'(i) < s.count && !msr_mapped(s.addr + 16'(i))) begin
        span_bad = 1'b1;
      end
    end
    unique case (s.func)
      MSR_FC_READ: begin
        check_code = span_long ? MSR_EXC_DATA :
                     (span_bad ? MSR_EXC_ADDR : MSR_EXC_NONE);
      end
      MSR_FC_WRITE_ONE: begin
        // Every word here is read-only: a mapped target cannot be written
        check_code = msr_mapped(s.addr) ? MSR_EXC_EXEC : MSR_EXC_ADDR;
      end
      MSR_FC_WRITE_MANY: begin
        check_code = span_long ? MSR_EXC_DATA :
                     (span_bad ? MSR_EXC_ADDR : MSR_EXC_EXEC);
      end
      default: check_code = MSR_EXC_FUNC;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.resp_valid = 1'b0;
    next_s.resp_last = 1'b0;
    next_s.resp_exception = 1'b0;

    if (delay_load) begin
      next_s.delay_tenths = (delay_tenths > MSR_DELAY_MAX_TENTHS) ?
                            MSR_DELAY_MAX_TENTHS : delay_tenths;
    end

    next_s.state_flags = 16'h0000;
    next_s.state_flags[MSR_B_DIR_HI:MSR_B_DIR_LO] = dir_code;
    next_s.state_flags[MSR_B_RDY_HI:MSR_B_RDY_LO] =
      drive_fault ? MSR_RDY_ERR : MSR_RDY_OK;
    next_s.state_flags[MSR_B_OUTPUT] = drive_output;
    next_s.state_flags[MSR_B_ALARM] = drive_alarm;
    next_s.ctrl_mode = torque_mode ? MSR_MODE_TORQUE : MSR_MODE_SPEED;

    next_s.prev_dir = dir_code;
    if (dir_code != s.prev_dir || stop_display_zero) begin
      next_s.enc_revs = 16'h0000;
    end else if (first_encoder_input && s.enc_revs != MSR_WORD_MAX) begin
      next_s.enc_revs = s.enc_revs + 16'h0001;
    end

    next_s.prev_run = drive_running;
    if (drive_running && !s.prev_run) begin
      next_s.turns = 16'h0000;
      next_s.op_pos = 16'h0000;
    end else if (drive_running) begin
      if (motor_turn_tick) begin
        next_s.turns = s.turns + 16'h0001;
      end
      if (motor_position_tick) begin
        next_s.op_pos = s.op_pos + 16'h0001;
      end
    end

    if (second_encoder_input && s.pg2_pos != MSR_WORD_MAX) begin
      next_s.pg2_pos = s.pg2_pos + 16'h0001;
    end
    if (pulse_input_terminal) begin
      next_s.term_cnt = s.term_cnt + 32'h0000_0001;
    end

    unique case (s.state)
      MSR_IDLE: begin
        if (req_valid) begin
          next_s.func = req_func;
          next_s.addr = req_addr;
          next_s.count = req_count;
          next_s.idx = 16'h0000;
          next_s.state = MSR_CHECK;
        end
      end
      MSR_CHECK: begin
        next_s.exc = check_code;
        next_s.tenth_cnt = s.delay_tenths;
        next_s.step_cnt = STEP_LAST;
        next_s.state = (s.delay_tenths == 16'h0000) ? MSR_SEND : MSR_WAIT;
      end
      MSR_WAIT: begin
        if (s.step_cnt == 16'h0000) begin
          next_s.step_cnt = STEP_LAST;
          next_s.tenth_cnt = s.tenth_cnt - 16'h0001;
          if (s.tenth_cnt == 16'h0001) begin
            next_s.state = MSR_SEND;
          end
        end else begin
          next_s.step_cnt = s.step_cnt - 16'h0001;
        end
      end
      MSR_SEND: begin
        next_s.resp_valid = 1'b1;
        next_s.beat_addr = rd_addr;
        if (s.exc != MSR_EXC_NONE) begin
          next_s.resp_exception = 1'b1;
          next_s.resp_func = s.func | MSR_EXC_FLAG;
          next_s.resp_code = s.exc;
          next_s.resp_word = 16'h0000;
          next_s.resp_last = 1'b1;
          next_s.state = MSR_IDLE;
        end else begin
          next_s.resp_func = s.func;
          next_s.resp_code = MSR_EXC_NONE;
          next_s.resp_word = rd_word;
          next_s.idx = s.idx + 16'h0001;
          if (s.idx == s.count - 16'h0001) begin
            next_s.resp_last = 1'b1;
            next_s.state = MSR_IDLE;
          end
        end
      end
    endcase
    next_s.busy = (next_s.state != MSR_IDLE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.state <= MSR_IDLE;
      s.delay_tenths <= MSR_DELAY_DEF_TENTHS;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign resp_valid = s.resp_valid;
  assign resp_exception = s.resp_exception;
  assign resp_last = s.resp_last;
  assign resp_func = s.resp_func;
  assign resp_code = s.resp_code;
  assign resp_word = s.resp_word;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_exc_beat;
    s.resp_valid && s.resp_exception;
  endsequence

  property p_exc_func;
    @(posedge clk) disable iff (rst)
    s_exc_beat |-> s.resp_func[7] && s.resp_func == (s.func | MSR_EXC_FLAG)
      && s.resp_last;
  endproperty
  a_exc_func: assert property (p_exc_func)
    else $error("exception reply lacks flagged function code");

  property p_bad_func_code;
    @(posedge clk) disable iff (rst)
    ce && s.state == MSR_CHECK && s.func != MSR_FC_READ
      && s.func != MSR_FC_WRITE_ONE && s.func != MSR_FC_WRITE_MANY
      |=> s.exc == MSR_EXC_FUNC;
  endproperty
  a_bad_func_code: assert property (p_bad_func_code)
    else $error("unknown function not given code 1");

  property p_exc_range;
    @(posedge clk) disable iff (rst)
    s_exc_beat |-> s.resp_code >= MSR_EXC_FUNC && s.resp_code <= MSR_EXC_EXEC;
  endproperty
  a_exc_range: assert property (p_exc_range)
    else $error("exception code outside 1 to 4");

  property p_wait_holds;
    @(posedge clk) disable iff (rst)
    ce && s.state == MSR_WAIT && s.step_cnt != 16'h0000
      |=> s.state == MSR_WAIT;
  endproperty
  a_wait_holds: assert property (p_wait_holds)
    else $error("reply sent before delay elapsed");

  property p_zero_delay;
    @(posedge clk) disable iff (rst)
    ce && s.state == MSR_CHECK && s.delay_tenths == 16'h0000
      |=> s.state == MSR_SEND;
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("zero delay did not reply at once");

  property p_flags;
    @(posedge clk) disable iff (rst)
    ce |=> s.state_flags[1:0] == $past(dir_code)
      && s.state_flags[3:2] == ($past(drive_fault) ? MSR_RDY_ERR : MSR_RDY_OK)
      && s.state_flags[4] == $past(drive_output)
      && s.state_flags[5] == $past(drive_alarm);
  endproperty
  a_flags: assert property (p_flags)
    else $error("drive state word does not follow drive");

  property p_mode;
    @(posedge clk) disable iff (rst)
    ce |=> s.ctrl_mode == {15'h0000, $past(torque_mode)};
  endproperty
  a_mode: assert property (p_mode)
    else $error("control mode word wrong");

  property p_enc_restart;
    @(posedge clk) disable iff (rst)
    ce && (stop_display_zero || dir_code != s.prev_dir) |=> s.enc_revs == '0;
  endproperty
  a_enc_restart: assert property (p_enc_restart)
    else $error("revolution count did not restart");

  property p_start_clears;
    @(posedge clk) disable iff (rst)
    ce && drive_running && !s.prev_run |=> s.turns == '0 && s.op_pos == '0;
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("start did not clear turns and position");

  property p_stop_holds;
    @(posedge clk) disable iff (rst)
    !drive_running |=> s.turns == $past(s.turns) && s.op_pos == $past(s.op_pos);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("turns or position moved while stopped");

  property p_pg2_sat;
    @(posedge clk) disable iff (rst)
    s.pg2_pos == MSR_WORD_MAX |=> s.pg2_pos == MSR_WORD_MAX;
  endproperty
  a_pg2_sat: assert property (p_pg2_sat)
    else $error("pulse position wrapped");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
    s.resp_valid && !s.resp_exception && s.beat_addr == MSR_A_RESERVED
      |-> s.resp_word == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved word read non-zero");

endmodule : msr_responder

// ==== verification/msr_master.sv ====
// Modbus master model that sends one request and gathers its reply beats
module msr_master (
  input wire logic clk,
  input wire logic busy,
  input wire logic resp_valid,
  input wire logic resp_exception,
  input wire logic resp_last,
  input wire logic [7:0] resp_func,
  input wire logic [7:0] resp_code,
  input wire logic [15:0] resp_word,
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] words[$];
  logic [7:0] exc_func, exc_code;
  logic exc, busy_ok;
  int lat;
  initial begin
    req_valid = 1'b0;
    {req_func, req_addr, req_count} = 40'h00_0000_0000;
  end
  task automatic ask(input logic [7:0] f, input logic [15:0] a,
                     input logic [15:0] n);
    words.delete();
    lat = 0;
    busy_ok = 1'b0;
    @(negedge clk);
    req_valid = 1'b1;
    {req_func, req_addr, req_count} = {f, a, n};
    while (busy !== 1'b0) @(negedge clk);
    @(posedge clk);
    for (int k = 1; k < 9000; k++) begin
      @(negedge clk);
      if (k == 1) begin
        // Released lines show the inverse so a late sample cannot match
        req_valid = 1'b0;
        {req_func, req_addr, req_count} = ~{f, a, n};
        busy_ok = (busy === 1'b1);
      end
      if (resp_valid === 1'b1) begin
        if (lat == 0) lat = k;
        words.push_back(resp_word);
        {exc, exc_func, exc_code} = {resp_exception, resp_func, resp_code};
        if (resp_last === 1'b1) begin
          // Busy must have dropped by the last beat of the reply
          busy_ok = busy_ok && (busy === 1'b0);
          break;
        end
      end
    end
  endtask : ask
endmodule : msr_master

// ==== verification/msr_responder_tb.sv ====
// Self-checking bench of the Modbus status and exception responder
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module msr_responder_tb import msr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 4;
  int n_errors = 0;
  int n_tests = 0;
  logic clk, rst, ce, delay_load, run_forward, run_reverse, drive_fault;
  logic drive_output, drive_alarm, torque_mode, drive_running;
  logic stop_display_zero, req_valid, busy, resp_valid, resp_exception;
  logic resp_last;
  logic [4:0] tick;
  logic [7:0] req_func, resp_func, resp_code;
  logic [15:0] delay_tenths, pw, req_addr, req_count, resp_word;
  logic [31:0] motor_actual_position;
  msr_responder #(.DELAY_STEP_CYCLES(STEP)) dut (
    .clk, .rst, .ce, .req_valid, .req_func, .req_addr, .req_count,
    .delay_load, .delay_tenths, .run_forward, .run_reverse, .drive_fault,
    .drive_output, .drive_alarm, .torque_mode, .drive_running,
    .stop_display_zero, .first_encoder_input(tick[0]),
    .second_encoder_input(tick[1]), .pulse_input_terminal(tick[2]),
    .motor_turn_tick(tick[3]), .motor_position_tick(tick[4]),
    .motor_actual_position, .digital_output_state(pw),
    .active_multistep_speed(~pw), .input_pin_state(pw ^ 16'h00FF),
    .output_pin_state(pw ^ 16'hFF00), .pulse_input_frequency(pw),
    .position_tracking_error(pw), .overload_counter_percent(pw),
    .magnet_motor_poles(pw), .user_page_value(pw),
    .selected_display_output(pw), .fan_speed_percent(pw),
    .carrier_frequency(pw), .estimated_output_torque(pw),
    .torque_command_percent(pw), .energy_kwh(pw), .hardware_identity(pw),
    .master_frequency_display(pw), .combined_frequency_display(pw),
    .busy, .resp_valid, .resp_exception, .resp_last, .resp_func,
    .resp_code, .resp_word
  );
  msr_master m (
    .clk, .busy, .resp_valid, .resp_exception, .resp_last, .resp_func,
    .resp_code, .resp_word, .req_valid, .req_func, .req_addr, .req_count
  );
  task automatic tally_and_finish;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic pulses(input int i, input int n);
    repeat (n) begin
      @(negedge clk);
      tick[i] = 1'b1;
      @(negedge clk);
      tick[i] = 1'b0;
    end
  endtask : pulses
  task automatic rd2(input logic [15:0] a, input logic [15:0] e0,
                     input logic [15:0] e1);
    m.ask(MSR_FC_READ, a, 16'h0002);
    `CHK(m.words[0], e0)
    `CHK(m.words[1], e1)
    `CHK(m.busy_ok, 1'b1)
    `CHK({m.exc, m.exc_func, m.exc_code}, {1'b0, MSR_FC_READ, 8'h00})
  endtask : rd2
  task automatic set_delay(input logic [15:0] d);
    @(negedge clk);
    {delay_load, delay_tenths} = {1'b1, d};
    @(negedge clk);
    delay_load = 1'b0;
  endtask : set_delay
  task automatic t_delay;
    m.ask(MSR_FC_READ, MSR_A_CTRL_MODE, 16'h0001);
    `CHK(m.lat, 3 + 20 * STEP)
    set_delay(16'h0002);
    m.ask(MSR_FC_READ, MSR_A_CTRL_MODE, 16'h0001);
    `CHK(m.lat, 3 + 2 * STEP)
    // Clock enable low for five edges stretches the wait by five cycles
    fork
      m.ask(MSR_FC_READ, MSR_A_CTRL_MODE, 16'h0001);
      begin
        repeat (3) @(negedge clk);
        ce = 1'b0;
        repeat (5) @(negedge clk);
        ce = 1'b1;
      end
    join
    `CHK(m.lat, 3 + 2 * STEP + 5)
    // Above the ceiling the setting clamps, the longest wait of the run
    set_delay(16'h0BB8);
    m.ask(MSR_FC_READ, MSR_A_CTRL_MODE, 16'h0001);
    `CHK(m.lat, 3 + 2000 * STEP)
    set_delay(16'h0000);
    m.ask(MSR_FC_READ, MSR_A_CTRL_MODE, 16'h0001);
    `CHK(m.lat, 3)
  endtask : t_delay
  task automatic t_status;
    {run_forward, run_reverse, drive_fault, drive_output} = 4'b1001;
    rd2(MSR_A_STATE_FLAGS, 16'h0015, pw);
    {run_forward, run_reverse, drive_fault, drive_output} = 4'b0110;
    drive_alarm = 1'b1;
    rd2(MSR_A_STATE_FLAGS, 16'h002A, pw);
    {run_reverse, drive_fault, drive_alarm, torque_mode} = 4'b0001;
    rd2(MSR_A_STATE_FLAGS, 16'h0004, pw);
    rd2(MSR_A_CTRL_MODE, MSR_MODE_TORQUE, pw);
    torque_mode = 1'b0;
    rd2(MSR_A_CTRL_MODE, MSR_MODE_SPEED, pw);
    rd2(MSR_A_CARRIER, pw, 16'h0000);
    rd2(MSR_A_DOUT_STATE, pw, ~pw);
    rd2(MSR_A_IN_PINS, pw ^ 16'h00FF, pw ^ 16'hFF00);
  endtask : t_status
  task automatic t_exc;
    logic [7:0] fs[7] = '{8'h07, MSR_FC_READ, MSR_FC_READ, MSR_FC_READ,
      MSR_FC_WRITE_ONE, MSR_FC_WRITE_MANY, MSR_FC_READ};
    logic [15:0] as[7] = '{MSR_A_TURNS, 16'h221A, MSR_A_TURNS,
      MSR_A_TURNS, MSR_A_TURNS, MSR_A_TURNS, MSR_A_HW_ID};
    logic [15:0] ns[7] = '{16'h0001, 16'h0001, 16'h0000, 16'h0009,
      16'h0001, 16'h0002, 16'h0002};
    logic [7:0] cs[7] = '{MSR_EXC_FUNC, MSR_EXC_ADDR, MSR_EXC_DATA,
      MSR_EXC_DATA, MSR_EXC_EXEC, MSR_EXC_EXEC, MSR_EXC_ADDR};
    for (int i = 0; i < 7; i++) begin
      m.ask(fs[i], as[i], ns[i]);
      `CHK({m.exc, m.words.size()}, 33'h1_0000_0001)
      `CHK(m.exc_func, fs[i] | MSR_EXC_FLAG)
      `CHK(m.exc_code, cs[i])
    end
  endtask : t_exc
  task automatic t_counts;
    run_forward = 1'b1;
    pulses(0, 3);
    rd2(MSR_A_ENC_REVS, 16'h0003, pw);
    {run_forward, run_reverse} = 2'b01;
    pulses(0, 2);
    pulses(1, 3);
    rd2(MSR_A_ENC_REVS, 16'h0002, pw);
    rd2(MSR_A_PULSE_POS, 16'h0003, pw);
    stop_display_zero = 1'b1;
    pulses(2, 5);
    stop_display_zero = 1'b0;
    rd2(MSR_A_ENC_REVS, 16'h0000, pw);
    rd2(MSR_A_TERM_LOW, 16'h0005, 16'h0000);
    rd2(MSR_A_MPOS_LOW, 16'h5678, 16'h1234);
    drive_running = 1'b1;
    pulses(3, 3);
    pulses(4, 2);
    drive_running = 1'b0;
    pulses(3, 1);
    rd2(MSR_A_TURNS, 16'h0003, 16'h0002);
    drive_running = 1'b1;
    rd2(MSR_A_TURNS, 16'h0000, 16'h0000);
    // One tick per cycle runs both counters into their ceiling
    tick[1:0] = 2'b11;
    repeat (65536) @(negedge clk);
    tick[1:0] = 2'b00;
    rd2(MSR_A_ENC_REVS, MSR_WORD_MAX, pw);
    rd2(MSR_A_PULSE_POS, MSR_WORD_MAX, pw);
  endtask : t_counts
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    // The saturation run dominates: about 75k cycles in all
    #900000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    {rst, ce, delay_tenths, pw} = {2'b11, 16'h0000, 16'hA55A};
    {delay_load, run_forward, run_reverse, drive_fault} = 4'h0;
    {drive_output, drive_alarm, torque_mode, drive_running} = 4'h0;
    {stop_display_zero, tick} = 6'h00;
    motor_actual_position = 32'h1234_5678;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_delay();
    t_status();
    t_exc();
    t_counts();
    tally_and_finish();
  end
endmodule : msr_responder_tb
